// File: chgi_dev.sv
`timescale 1ns/10ps
`default_nettype none
module chgi_dev
  import chgi_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  input wire logic LINK_CLK_IN,
  chgi_if.dev BUS,
  input wire logic SW_CYCLE_IN,
  input wire logic ILIM_ACTIVE_IN,
  input wire logic BAT_UV_IN,
  input wire logic [1:0] CHARGE_STATE_IN,
  input wire logic EXT_FAULT_STB_IN,
  input wire logic [2:0] EXT_FAULT_CODE_IN,
  output logic BOOST_MODE_OUT,
  output logic WATCHDOG_KICK_OUT,
  output logic FAULT_PULL_OE_OUT
);
  import chgi_pkg::*;

  typedef struct packed {
    logic sw_m, sw_s, sw_d;
    logic il_m, il_s;
    logic uv_m, uv_s;
    logic wr_m, wr_s, wr_d;
    logic rd_m, rd_s, rd_d;
    logic ack_m, ack_s;
    logic req;
    logic [7:0] snap;
    logic boost;
    logic [2:0] fault;
    logic [3:0] ilim_cnt;
    logic [11:0] pulse_cnt;
    logic pulse_on;
    logic kick;
  } chgi_core_t;

  typedef struct packed {
    logic scl_m, scl_s, scl_d;
    logic sda_m, sda_s, sda_d;
    logic req_m, req_s;
    logic ack;
    logic [7:0] status;
    chgi_link_st_t st;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [1:0] phase;
    logic rw;
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic wr_tgl;
    logic rd_tgl;
    logic sda_oe;
  } chgi_link_t;

  chgi_core_t c_reg, c_next;
  chgi_link_t l_reg, l_next;

  function automatic logic [7:0] tx_byte(input logic [7:0] ptr, input logic [7:0] status);
    tx_byte = (ptr == REG_STATUS_CTRL) ? status : UNMAPPED_DATA;
  endfunction

  // Core domain: mode, fault and pulse logic
  logic wr_ev, rd_ev, oc_ev, uv_ev, fault_ev;
  logic [2:0] ev_code;
  logic [3:0] cnt_inc;
  always_comb
  begin
    c_next = c_reg;
    c_next.sw_m = SW_CYCLE_IN;
    c_next.sw_s = c_reg.sw_m;
    c_next.sw_d = c_reg.sw_s;
    c_next.il_m = ILIM_ACTIVE_IN;
    c_next.il_s = c_reg.il_m;
    c_next.uv_m = BAT_UV_IN;
    c_next.uv_s = c_reg.uv_m;
    c_next.wr_m = l_reg.wr_tgl;
    c_next.wr_s = c_reg.wr_m;
    c_next.wr_d = c_reg.wr_s;
    c_next.rd_m = l_reg.rd_tgl;
    c_next.rd_s = c_reg.rd_m;
    c_next.rd_d = c_reg.rd_s;
    c_next.ack_m = l_reg.ack;
    c_next.ack_s = c_reg.ack_m;
    // Pointer and data are held by the link side well past the toggle
    wr_ev = (c_reg.wr_s ^ c_reg.wr_d) && (l_reg.ptr == REG_STATUS_CTRL);
    rd_ev = c_reg.rd_s ^ c_reg.rd_d;
    cnt_inc = c_reg.ilim_cnt + 4'h1;
    oc_ev = 1'b0;
    if (!c_reg.boost)
    begin
      c_next.ilim_cnt = 4'h0;
    end
    else if (c_reg.sw_s && !c_reg.sw_d)
    begin
      if (!c_reg.il_s)
      begin
        c_next.ilim_cnt = 4'h0;
      end
      else if (cnt_inc == OVERLOAD_CYCLES)
      begin
        oc_ev = 1'b1;
        c_next.ilim_cnt = 4'h0;
      end
      else
      begin
        c_next.ilim_cnt = cnt_inc;
      end
    end
    uv_ev = c_reg.boost && c_reg.uv_s;
    fault_ev = oc_ev || uv_ev || EXT_FAULT_STB_IN;
    ev_code = (oc_ev || uv_ev) ? FLT_LOW_SUPPLY : EXT_FAULT_CODE_IN;
    // Clear on read first, so a fault in the same cycle still lands
    if (rd_ev)
    begin
      c_next.fault = FLT_NONE;
    end
    if (fault_ev && (c_next.fault == FLT_NONE))
    begin
      c_next.fault = ev_code;
    end
    c_next.kick = wr_ev && l_reg.wdata[KICK_BIT];
    if (wr_ev)
    begin
      // Setting boost refused while undervoltage or an unread fault stands
      c_next.boost = l_reg.wdata[BOOST_BIT] && !c_reg.uv_s
                     && (c_reg.fault == FLT_NONE);
    end
    if (oc_ev || uv_ev)
    begin
      c_next.boost = 1'b0;
    end
    if (fault_ev)
    begin
      c_next.pulse_cnt = FAULT_PULSE_CYC;
    end
    else if (c_reg.pulse_cnt != 12'h000)
    begin
      c_next.pulse_cnt = c_reg.pulse_cnt - 12'h001;
    end
    c_next.pulse_on = c_next.pulse_cnt != 12'h000;
    // Status word sent across by req/ack handshake, reloaded each round
    if (c_reg.ack_s == c_reg.req)
    begin
      c_next.snap = {1'b0, c_reg.boost, CHARGE_STATE_IN, 1'b0, c_reg.fault};
      c_next.req = ~c_reg.req;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      c_reg <= '0;
    end
    else
    begin
      c_reg <= c_next;
    end
  end

  assign BOOST_MODE_OUT = c_reg.boost;
  assign WATCHDOG_KICK_OUT = c_reg.kick;
  assign FAULT_PULL_OE_OUT = c_reg.pulse_on;

  // Link domain: oversampled two-wire slave
  logic rise, fall, start_c, stop_c;
  logic [7:0] nb;
  always_comb
  begin
    l_next = l_reg;
    l_next.scl_m = BUS.scl;
    l_next.scl_s = l_reg.scl_m;
    l_next.scl_d = l_reg.scl_s;
    l_next.sda_m = BUS.sda;
    l_next.sda_s = l_reg.sda_m;
    l_next.sda_d = l_reg.sda_s;
    l_next.req_m = c_reg.req;
    l_next.req_s = l_reg.req_m;
    if (l_reg.req_s != l_reg.ack)
    begin
      l_next.status = c_reg.snap;
      l_next.ack = l_reg.req_s;
    end
    rise = l_reg.scl_s && !l_reg.scl_d;
    fall = !l_reg.scl_s && l_reg.scl_d;
    start_c = l_reg.scl_s && l_reg.scl_d && l_reg.sda_d && !l_reg.sda_s;
    stop_c = l_reg.scl_s && l_reg.scl_d && !l_reg.sda_d && l_reg.sda_s;
    nb = tx_byte(l_reg.ptr, l_reg.status);
    case (l_reg.st)
      LK_IDLE:
      begin
        l_next.sda_oe = 1'b0;
      end
      LK_RX:
      begin
        if (rise)
        begin
          l_next.sh = {l_reg.sh[6:0], l_reg.sda_s};
          l_next.bits = l_reg.bits + 4'h1;
        end
        else if (fall && l_reg.bits == BITS_PER_BYTE)
        begin
          if (l_reg.phase == PH_ADDR)
          begin
            if (l_reg.sh[7:1] == SLAVE_ADDR)
            begin
              l_next.sda_oe = 1'b1;
              l_next.rw = l_reg.sh[0];
              l_next.st = LK_ACK;
            end
            else
            begin
              l_next.st = LK_IDLE;
            end
          end
          else
          begin
            l_next.sda_oe = 1'b1;
            l_next.st = LK_ACK;
            if (l_reg.phase == PH_PTR)
            begin
              l_next.ptr = l_reg.sh;
            end
            else
            begin
              l_next.wdata = l_reg.sh;
              l_next.wr_tgl = ~l_reg.wr_tgl;
            end
          end
        end
      end
      LK_ACK:
      begin
        if (fall)
        begin
          l_next.bits = 4'h0;
          if (l_reg.phase == PH_ADDR && l_reg.rw)
          begin
            l_next.sh = nb;
            l_next.sda_oe = ~nb[7];
            l_next.st = LK_TX;
            l_next.phase = PH_DATA;
            l_next.rd_tgl = l_reg.rd_tgl ^ (l_reg.ptr == REG_STATUS_CTRL);
          end
          else
          begin
            l_next.sda_oe = 1'b0;
            l_next.st = LK_RX;
            l_next.phase = (l_reg.phase == PH_ADDR) ? PH_PTR : PH_DATA;
          end
        end
      end
      LK_TX:
      begin
        if (fall)
        begin
          l_next.bits = l_reg.bits + 4'h1;
          if (l_reg.bits == BITS_PER_BYTE - 4'h1)
          begin
            l_next.sda_oe = 1'b0;
            l_next.st = LK_TXACK;
          end
          else
          begin
            l_next.sh = {l_reg.sh[6:0], 1'b1};
            l_next.sda_oe = ~l_reg.sh[6];
          end
        end
      end
      LK_TXACK:
      begin
        if (rise)
        begin
          // Master's not-acknowledge ends our part until the next START
          l_next.st = l_reg.sda_s ? LK_IDLE : LK_TXACK;
          l_next.bits = BITS_PER_BYTE;
        end
        else if (fall && l_reg.bits == BITS_PER_BYTE)
        begin
          l_next.bits = 4'h0;
          l_next.sh = nb;
          l_next.sda_oe = ~nb[7];
          l_next.st = LK_TX;
          l_next.rd_tgl = l_reg.rd_tgl ^ (l_reg.ptr == REG_STATUS_CTRL);
        end
      end
      default:
      begin
        l_next.st = LK_IDLE;
      end
    endcase
    if (stop_c)
    begin
      l_next.st = LK_IDLE;
      l_next.sda_oe = 1'b0;
    end
    if (start_c)
    begin
      l_next.st = LK_RX;
      l_next.bits = 4'h0;
      l_next.phase = PH_ADDR;
      l_next.sda_oe = 1'b0;
    end
  end

  always_ff @(posedge LINK_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      l_reg <= '0;
      l_reg.scl_m <= 1'b1;
      l_reg.scl_s <= 1'b1;
      l_reg.scl_d <= 1'b1;
      l_reg.sda_m <= 1'b1;
      l_reg.sda_s <= 1'b1;
      l_reg.sda_d <= 1'b1;
    end
    else
    begin
      l_reg <= l_next;
    end
  end

  // One protocol engine serves both rates
  assign BUS.sda_dev_oe = l_reg.sda_oe;
endmodule // chgi_dev
`default_nettype wire

// File: chgi_pkg.sv
// Overview of operation
// - Overload after 8 consecutive current-limited switching cycles
// - Overload stops boost, records fault, pulses output
// - Boost resumes only after fault cleared and rewritten
// - Battery undervoltage in boost stops boost, faults
// - Boost restarts only after battery recovery and rewrite
// - Slave only; standard and fast rates alike
// - Seven-bit addressing, fixed address 1101011
// - Master starts with START; device detects it
// - Data line stable while clock is high
// - Matching address acknowledged on ninth clock only
// - Direction bit picks write or read; receiver acknowledges
// - Byte plus acknowledge, repeated without limit
// - STOP releases link; wait for new START
// - Abandoned transfer still ends with STOP
// - Unimplemented register reads return all ones
// - Bit 7 write kicks watchdog; reads zero
// - Bit 6 selects boost mode, resets zero
// - Bits 5:4 report live charge state
// - Bits 2:0 hold the fault code
// - First fault latched until register read
// - Fault gives one 128 us low pulse
package chgi_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h6B;
  localparam logic [7:0] REG_STATUS_CTRL = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'hFF;
  localparam int KICK_BIT = 7;
  localparam int BOOST_BIT = 6;
  localparam logic [2:0] FLT_NONE = 3'h0;
  localparam logic [2:0] FLT_LOW_SUPPLY = 3'h2;
  localparam logic [3:0] OVERLOAD_CYCLES = 4'h8;
  localparam int MCLK_PERIOD_NS = 50;
  localparam int FAULT_PULSE_US = 128;
  localparam logic [11:0] FAULT_PULSE_CYC =
    12'((FAULT_PULSE_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam int SCL_PERIOD_NS = 2500;
  localparam logic [7:0] SCL_QUARTER_CYC =
    8'((SCL_PERIOD_NS / 4 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_PTR = 2'h1;
  localparam logic [1:0] PH_DATA = 2'h2;
  typedef enum logic [2:0] {LK_IDLE, LK_RX, LK_ACK, LK_TX, LK_TXACK} chgi_link_st_t;
  typedef enum logic [2:0] {HS_IDLE, HS_START, HS_BYTE, HS_RSTART, HS_STOP} chgi_host_st_t;
endpackage

// File: chgi_if.sv
`timescale 1ns/10ps
`default_nettype none
interface chgi_if;
  logic scl_oe;
  logic sda_host_oe;
  logic sda_dev_oe;
  wire scl;
  wire sda;
  // Pull-ups: a line is low only while someone drives it
  assign scl = ~scl_oe;
  assign sda = ~(sda_host_oe | sda_dev_oe);
  modport host (output scl_oe, output sda_host_oe, input scl, input sda);
  modport dev (output sda_dev_oe, input scl, input sda);
endinterface
`default_nettype wire

// File: chgi_host.sv
`timescale 1ns/10ps
`default_nettype none
module chgi_host
  import chgi_pkg::*;
#(
  parameter logic [7:0] QUARTER_CYC = SCL_QUARTER_CYC
)
(
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  chgi_if.host BUS,
  input wire logic CMD_VALID_IN,
  input wire logic CMD_READ_IN,
  input wire logic [7:0] CMD_REG_IN,
  input wire logic [7:0] CMD_DATA_IN,
  output logic CMD_READY_OUT,
  output logic RESP_VALID_OUT,
  output logic [7:0] RESP_DATA_OUT,
  output logic RESP_NACK_OUT
);
  import chgi_pkg::*;

  typedef struct packed {
    logic sda_m, sda_s;
    chgi_host_st_t st;
    logic [1:0] q;
    logic [7:0] tick;
    logic [3:0] bits;
    logic [8:0] sh;
    logic [1:0] step;
    logic rd;
    logic [7:0] reg_a;
    logic [7:0] data;
    logic scl_oe;
    logic sda_oe;
    logic resp_valid;
    logic [7:0] resp_data;
    logic resp_nack;
  } chgi_host_state_t;

  chgi_host_state_t h_reg, h_next;
  logic adv;

  always_comb
  begin
    h_next = h_reg;
    h_next.sda_m = BUS.sda;
    h_next.sda_s = h_reg.sda_m;
    h_next.resp_valid = 1'b0;
    adv = h_reg.tick == 8'h00;
    h_next.tick = adv ? QUARTER_CYC - 8'h01 : h_reg.tick - 8'h01;
    if (h_reg.st == HS_IDLE)
    begin
      h_next.tick = QUARTER_CYC - 8'h01;
      if (CMD_VALID_IN)
      begin
        h_next.rd = CMD_READ_IN;
        h_next.reg_a = CMD_REG_IN;
        h_next.data = CMD_DATA_IN;
        h_next.st = HS_START;
        h_next.q = 2'h0;
        h_next.step = 2'h0;
        h_next.resp_nack = 1'b0;
      end
    end
    else if (adv)
    begin
      h_next.q = h_reg.q + 2'h1;
      case (h_reg.st)
        HS_START, HS_RSTART:
        begin
          case (h_reg.q)
            2'h0: h_next.sda_oe = 1'b0;
            2'h1: h_next.scl_oe = 1'b0;
            2'h2: h_next.sda_oe = 1'b1;
            default:
            begin
              h_next.scl_oe = 1'b1;
              h_next.st = HS_BYTE;
              h_next.bits = 4'h0;
              h_next.sh = {SLAVE_ADDR, h_reg.st == HS_RSTART, 1'b1};
              h_next.step = h_reg.st == HS_RSTART ? 2'h2 : 2'h0;
            end
          endcase
        end
        HS_BYTE:
        begin
          case (h_reg.q)
            2'h0: h_next.sda_oe = ~h_reg.sh[8];
            2'h1: h_next.scl_oe = 1'b0;
            2'h2: h_next.sh = {h_reg.sh[7:0], h_reg.sda_s};
            default:
            begin
              h_next.scl_oe = 1'b1;
              h_next.bits = h_reg.bits + 4'h1;
              if (h_reg.bits == BITS_PER_BYTE)
              begin
                h_next.bits = 4'h0;
                h_next.step = h_reg.step + 2'h1;
                if (h_reg.step == 2'h3)
                begin
                  h_next.resp_data = h_reg.sh[8:1];
                  h_next.st = HS_STOP;
                end
                else if (h_reg.sh[0])
                begin
                  h_next.resp_nack = 1'b1;
                  h_next.st = HS_STOP;
                end
                else if (h_reg.step == 2'h0)
                begin
                  h_next.sh = {h_reg.reg_a, 1'b1};
                end
                else if (h_reg.step == 2'h1)
                begin
                  h_next.sh = {h_reg.data, 1'b1};
                  h_next.st = h_reg.rd ? HS_RSTART : HS_BYTE;
                end
                else
                begin
                  // Released byte plus not-acknowledge ends the read
                  h_next.sh = 9'h1FF;
                  h_next.st = h_reg.rd ? HS_BYTE : HS_STOP;
                end
              end
            end
          endcase
        end
        HS_STOP:
        begin
          case (h_reg.q)
            2'h0: h_next.sda_oe = 1'b1;
            2'h1: h_next.scl_oe = 1'b0;
            2'h2: h_next.sda_oe = 1'b0;
            default:
            begin
              h_next.st = HS_IDLE;
              h_next.resp_valid = 1'b1;
            end
          endcase
        end
        default:
        begin
          h_next.st = HS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      h_reg <= '0;
      h_reg.sda_m <= 1'b1;
      h_reg.sda_s <= 1'b1;
    end
    else
    begin
      h_reg <= h_next;
    end
  end

  assign BUS.scl_oe = h_reg.scl_oe;
  assign BUS.sda_host_oe = h_reg.sda_oe;
  assign CMD_READY_OUT = h_reg.st == HS_IDLE;
  assign RESP_VALID_OUT = h_reg.resp_valid;
  assign RESP_DATA_OUT = h_reg.resp_data;
  assign RESP_NACK_OUT = h_reg.resp_nack;
endmodule // chgi_host
`default_nettype wire

// File: chgi_properties.sv
`timescale 1ns/10ps
`default_nettype none
module chgi_properties
  import chgi_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  input wire logic scl_oe,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe,
  input wire logic scl,
  input wire logic sda
);
  import chgi_pkg::*;
  logic scl_q;
  logic sda_q;
  logic in_frame;
  logic rd;
  logic [4:0] cnt;
  logic [7:0] addr_sh;
  logic scl_rise;
  logic match;
  assign scl_rise = scl & ~scl_q;
  assign match = addr_sh[7:1] == SLAVE_ADDR;
  // Bit counter restarts at every start, so repeated starts are tracked too
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      in_frame <= 1'b0;
      rd <= 1'b0;
      cnt <= 5'h00;
      addr_sh <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda)
      begin
        in_frame <= 1'b1;
        cnt <= 5'h00;
      end
      else if (scl && scl_q && !sda_q && sda)
        in_frame <= 1'b0;
      else if (scl_rise)
      begin
        if (cnt != 5'h1F)
          cnt <= cnt + 5'h01;
        if (cnt < 5'h08)
          addr_sh <= {addr_sh[6:0], sda};
        if (cnt == 5'h08)
          rd <= addr_sh[0];
      end
    end
  end
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  sequence addr_ack_slot;
    scl_rise && in_frame && cnt == 5'h08 && match;
  endsequence
  sequence write_ack_slot;
    scl_rise && in_frame && !rd && (cnt == 5'h11 || cnt == 5'h1A);
  endsequence
  dev_sda_stable_a: assert property (scl && scl_q |-> $stable(sda_dev_oe))
    else $error("device data moved while clock high");
  addr_listen_a: assert property (in_frame && cnt < 5'h08 |-> !sda_dev_oe)
    else $error("device drove data during address");
  addr_ack_a: assert property (addr_ack_slot |-> sda_dev_oe [*3])
    else $error("address acknowledge missing");
  ack_release_a: assert property (addr_ack_slot ##0 !addr_sh[0] |-> ##[4:8] !sda_dev_oe)
    else $error("acknowledge not released");
  write_listen_a: assert property (in_frame && !rd && cnt >= 5'h0A && cnt <= 5'h10 |-> !sda_dev_oe)
    else $error("device drove data during write byte");
  write_ack_a: assert property (write_ack_slot |-> sda_dev_oe)
    else $error("write byte not acknowledged");
  read_release_a: assert property (scl_rise && in_frame && rd && cnt == 5'h11 |-> !sda_dev_oe)
    else $error("device held data in master acknowledge");
  idle_release_a: assert property (!in_frame |-> !sda_dev_oe)
    else $error("device drove data outside a frame");
  clock_idle_a: assert property (!in_frame |-> !scl_oe)
    else $error("master held clock low outside a frame");
  read_listen_a: assert property (in_frame && rd && cnt >= 5'h09 && cnt <= 5'h10 |-> !sda_host_oe)
    else $error("master drove data during read byte");
endmodule // chgi_properties
`default_nettype wire

// File: charger_i2c_slave_status_test.sv
`timescale 1ns/10ps
`default_nettype none
module charger_i2c_slave_status_test;
  import chgi_pkg::*;
  logic mclk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sw_cycle = 1'b0;
  logic ilim_active = 1'b0;
  logic bat_uv = 1'b0;
  logic [1:0] charge_state = 2'b10;
  logic ext_fault_stb = 1'b0;
  logic [2:0] ext_fault_code = 3'h5;
  logic boost_mode, watchdog_kick, fault_pull_oe;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready, resp_valid, resp_nack;
  logic [7:0] resp_data;
  int miscompares = 0;
  int comparisons = 0;
  int kicks = 0;
  always #25 mclk = ~mclk;
  always #7.5 link_clk = ~link_clk;
  always @(negedge mclk)
    if (watchdog_kick === 1'b1)
      kicks++;
  chgi_if bus();
  chgi_if bus_b();
  chgi_host #(.QUARTER_CYC(8'h02)) u_chgi_host (.MCLK_IN(mclk), .RESET_N_IN(reset_n),
    .BUS(bus), .CMD_VALID_IN(cmd_valid), .CMD_READ_IN(cmd_read), .CMD_REG_IN(cmd_reg),
    .CMD_DATA_IN(cmd_data), .CMD_READY_OUT(cmd_ready), .RESP_VALID_OUT(resp_valid),
    .RESP_DATA_OUT(resp_data), .RESP_NACK_OUT(resp_nack));
  chgi_dev u_chgi_dev (.MCLK_IN(mclk), .RESET_N_IN(reset_n), .LINK_CLK_IN(link_clk),
    .BUS(bus), .SW_CYCLE_IN(sw_cycle), .ILIM_ACTIVE_IN(ilim_active), .BAT_UV_IN(bat_uv),
    .CHARGE_STATE_IN(charge_state), .EXT_FAULT_STB_IN(ext_fault_stb),
    .EXT_FAULT_CODE_IN(ext_fault_code), .BOOST_MODE_OUT(boost_mode),
    .WATCHDOG_KICK_OUT(watchdog_kick), .FAULT_PULL_OE_OUT(fault_pull_oe));
  // Second end driven by hand so a wrong address and abandoned frames can be sent
  chgi_dev u_chgi_dev_b (.MCLK_IN(mclk), .RESET_N_IN(reset_n), .LINK_CLK_IN(link_clk),
    .BUS(bus_b), .SW_CYCLE_IN(sw_cycle), .ILIM_ACTIVE_IN(ilim_active), .BAT_UV_IN(bat_uv),
    .CHARGE_STATE_IN(charge_state), .EXT_FAULT_STB_IN(ext_fault_stb),
    .EXT_FAULT_CODE_IN(ext_fault_code), .BOOST_MODE_OUT(), .WATCHDOG_KICK_OUT(),
    .FAULT_PULL_OE_OUT());
  chgi_properties u_chgi_properties (.MCLK_IN(mclk), .RESET_N_IN(reset_n),
    .scl_oe(bus.scl_oe), .sda_host_oe(bus.sda_host_oe), .sda_dev_oe(bus.sda_dev_oe),
    .scl(bus.scl), .sda(bus.sda));
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_for(ref logic sig, input logic val);
    int n;
    for (n = 0; n < 3000 && sig !== val; n++)
      @(negedge mclk);
    if (n == 3000)
    begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic xfer(input logic rd, input logic [7:0] rg, input logic [7:0] wd);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_reg = rg;
    cmd_data = wd;
    @(negedge mclk);
    cmd_valid = 1'b0;
    check(16'(cmd_ready), 16'h0000);
    wait_for(resp_valid, 1'b1);
    check(16'(cmd_ready), 16'h0001);
  endtask
  task automatic rd_check(input logic [7:0] rg, input logic [7:0] exp);
    xfer(1'b1, rg, 8'h00);
    check(16'(resp_data), 16'(exp));
  endtask
  task automatic tick(input logic lim);
    @(negedge mclk);
    ilim_active = lim;
    sw_cycle = 1'b1;
    repeat (3) @(negedge mclk);
    sw_cycle = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  task automatic t_mode();
    int k0;
    xfer(1'b0, REG_STATUS_CTRL, 8'h40);
    check(16'(boost_mode), 16'h0001);
    check(16'(resp_nack), 16'h0000);
    for (int s = 0; s < 4; s++)
    begin
      charge_state = 2'(s);
      rd_check(REG_STATUS_CTRL, 8'h40 | 8'(s << 4));
    end
    charge_state = 2'b10;
    k0 = kicks;
    xfer(1'b0, REG_STATUS_CTRL, 8'hC0);
    check(16'(kicks - k0), 16'h0001);
    rd_check(REG_STATUS_CTRL, 8'h60);
    xfer(1'b0, 8'h05, 8'h00);
    rd_check(8'h05, UNMAPPED_DATA);
    rd_check(REG_STATUS_CTRL, 8'h60);
  endtask
  task automatic t_overload();
    realtime t0;
    repeat (7) tick(1'b1);
    tick(1'b0);
    repeat (7) tick(1'b1);
    check(16'(boost_mode), 16'h0001);
    // Eighth limited cycle by hand, so the pulse is timed from its first sample
    @(negedge mclk);
    sw_cycle = 1'b1;
    wait_for(fault_pull_oe, 1'b1);
    t0 = $realtime;
    sw_cycle = 1'b0;
    check(16'(boost_mode), 16'h0000);
    ilim_active = 1'b0;
    wait_for(fault_pull_oe, 1'b0);
    check(16'(($realtime - t0) / MCLK_PERIOD_NS), 16'(FAULT_PULSE_CYC));
    ext_fault_stb = 1'b1;
    @(negedge mclk);
    ext_fault_stb = 1'b0;
    xfer(1'b0, REG_STATUS_CTRL, 8'h40);
    check(16'(boost_mode), 16'h0000);
    rd_check(REG_STATUS_CTRL, 8'h22);
    rd_check(REG_STATUS_CTRL, 8'h20);
    xfer(1'b0, REG_STATUS_CTRL, 8'h40);
    check(16'(boost_mode), 16'h0001);
  endtask
  task automatic t_undervolt();
    bat_uv = 1'b1;
    wait_for(boost_mode, 1'b0);
    rd_check(REG_STATUS_CTRL, 8'h22);
    xfer(1'b0, REG_STATUS_CTRL, 8'h40);
    check(16'(boost_mode), 16'h0000);
    bat_uv = 1'b0;
    xfer(1'b0, REG_STATUS_CTRL, 8'h40);
    check(16'(boost_mode), 16'h0001);
  endtask
  task automatic bb_bit(input logic b, output logic got);
    bus_b.sda_host_oe = ~b;
    repeat (2) @(negedge mclk);
    bus_b.scl_oe = 1'b0;
    repeat (2) @(negedge mclk);
    got = bus_b.sda;
    bus_b.scl_oe = 1'b1;
    repeat (2) @(negedge mclk);
  endtask
  task automatic bb_addr(input logic [7:0] a, output logic ack);
    logic got;
    bus_b.sda_host_oe = 1'b1;
    repeat (2) @(negedge mclk);
    bus_b.scl_oe = 1'b1;
    for (int i = 7; i >= 0; i--)
      bb_bit(a[i], got);
    bb_bit(1'b1, ack);
  endtask
  task automatic bb_stop();
    bus_b.sda_host_oe = 1'b1;
    repeat (2) @(negedge mclk);
    bus_b.scl_oe = 1'b0;
    repeat (2) @(negedge mclk);
    bus_b.sda_host_oe = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  task automatic t_foreign();
    logic ack;
    logic got;
    bb_addr({7'h6A, 1'b0}, ack);
    check(16'(ack), 16'h0001);
    bb_stop();
    bb_addr({SLAVE_ADDR, 1'b0}, ack);
    check(16'(ack), 16'h0000);
    repeat (3) bb_bit(1'b0, got);
    bb_stop();
    bb_addr({SLAVE_ADDR, 1'b0}, ack);
    check(16'(ack), 16'h0000);
    bb_stop();
  endtask
  initial
  begin
    bus_b.scl_oe = 1'b0;
    bus_b.sda_host_oe = 1'b0;
    repeat (5) @(negedge mclk);
    reset_n = 1'b1;
    repeat (10) @(negedge mclk);
    rd_check(REG_STATUS_CTRL, 8'h20);
    t_mode();
    t_overload();
    t_undervolt();
    t_foreign();
    conclude();
  end
endmodule // charger_i2c_slave_status_test
`default_nettype wire
